// ### core/wdg_map.svh
// Register map, field positions, reset values and timing counts
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

// ------------------------------------------------------------
// Register indices (byte address is four times the index)
// ------------------------------------------------------------
`define WDG_CTRL_IDX 6'h24
`define WDG_STAT_IDX 6'h25
`define WDG_IRQ_STAT_IDX 6'h26
`define WDG_IRQ_MASK_IDX 6'h27

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define WDG_CTRL_ACT_BIT 7
`define WDG_CTRL_TOP_BIT 6
`define WDG_STAT_FLAG_BIT 0
`define WDG_IRQ_RESET_BIT 0
`define WDG_IRQ_STEP_BIT 1
`define WDG_CTRL_RESET 8'h7f
`define WDG_COUNT_RESET 7'h7f
`define WDG_IRQ_RESET 8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define WDG_STEP_CYCLES 32'h0000_c000
`define WDG_CLK_PERIOD_NS 50
`define WDG_RESET_PULSE_NS 500
`define WDG_RESET_PULSE_CYCLES \
    ((`WDG_RESET_PULSE_NS) / (`WDG_CLK_PERIOD_NS))

// ------------------------------------------------------------
// Bus responses
// ------------------------------------------------------------
`define WDG_RESP_OKAY 2'h0
`define WDG_RESP_SLVERR 2'h2

`endif

// ### core/wdg_pkg.sv
// Types shared by the watchdog modules
package wdg_pkg;

    // ------------------------------------------------------------
    // Reset sequencer states
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_RUN = 1'b0,
        ST_PULSE = 1'b1
    } wdg_state_t;

    typedef logic [6:0] countdown_t;
    typedef logic [1:0] axi_resp_t;

endpackage : wdg_pkg

// ### core/wdg_reg_if.sv
// Internal register access port between bus slave and register file
`timescale 1ns/1ps
interface wdg_reg_if;
    logic wr;
    logic rd;
    logic [5:0] index;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic hit;

    modport bus (output wr, rd, index, wdata, input rdata, hit);
    modport regs (input wr, rd, index, wdata, output rdata, hit);
endinterface : wdg_reg_if

// ### core/wdg_prescaler.sv
// Machine cycle prescaler producing one tick per countdown step
`timescale 1ns/1ps
`include "wdg_map.svh"
module wdg_prescaler #(
    parameter int unsigned CYCLES = `WDG_STEP_CYCLES
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Control
    input wire logic restart_in,
    // Step strobe
    output logic tick_out
);
    localparam int unsigned W = $clog2(CYCLES);
    localparam logic [W-1:0] LAST = W'(CYCLES - 1);

    logic [W-1:0] cnt;

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (CYCLES < 2) begin : g_bad_cycles
        $error("prescaler needs at least two cycles per step");
    end

    // Free-running divide, restarted on request
    always_ff @(posedge clk_in) begin
        if (rst_in || restart_in) begin
            cnt <= '0;
        end else if (cnt == LAST) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + W'(1);
        end
    end

    // One-cycle strobe on the last cycle of a step
    assign tick_out = (cnt == LAST) && !restart_in;
endmodule : wdg_prescaler

// ### core/axil_reg_slave.sv
// AXI4-Lite slave turning bus transfers into register strobes
`timescale 1ns/1ps
`include "wdg_map.svh"
module axil_reg_slave
    import wdg_pkg::*;
#(
    parameter int unsigned ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Write address and data
    input wire logic [ADDR_W-1:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    // Write response
    output axi_resp_t bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // Read address and data
    input wire logic [ADDR_W-1:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output axi_resp_t rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    // Register side
    wdg_reg_if.bus reg_port
);
    logic aw_held;
    logic [5:0] aw_idx;
    logic w_held;
    logic [7:0] wbyte;
    logic wlane;
    logic ar_held;
    logic [5:0] ar_idx;
    logic wr_go;
    logic rd_go;

    if (ADDR_W < 8) begin : g_bad_addr
        $error("address must be at least 8 bits wide");
    end

    // ------------------------------------------------------------
    // Handshakes and strobes
    // ------------------------------------------------------------
    assign awready_out = !aw_held && !bvalid_out;
    assign wready_out = !w_held && !bvalid_out;
    assign arready_out = !ar_held && !rvalid_out;
    assign wr_go = aw_held && w_held && !bvalid_out;
    assign rd_go = ar_held && !rvalid_out && !wr_go;
    assign reg_port.wr = wr_go && wlane;
    assign reg_port.rd = rd_go;
    assign reg_port.index = wr_go ? aw_idx : ar_idx;
    assign reg_port.wdata = wbyte;

    // Write address capture
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_held <= 1'b0;
            aw_idx <= 6'h00;
        end else if (awvalid_in && awready_out) begin
            aw_held <= 1'b1;
            aw_idx <= awaddr_in[7:2];
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    // Write data capture, only byte lane 0 carries register bits
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            w_held <= 1'b0;
            wbyte <= 8'h00;
            wlane <= 1'b0;
        end else if (wvalid_in && wready_out) begin
            w_held <= 1'b1;
            wbyte <= wdata_in[7:0];
            wlane <= wstrb_in[0];
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    // Write response one cycle after both halves are held
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            bvalid_out <= 1'b0;
            bresp_out <= `WDG_RESP_OKAY;
        end else if (wr_go) begin
            bvalid_out <= 1'b1;
            bresp_out <= reg_port.hit ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
        end else if (bready_in) begin
            bvalid_out <= 1'b0;
        end
    end

    // Read address capture
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ar_held <= 1'b0;
            ar_idx <= 6'h00;
        end else if (arvalid_in && arready_out) begin
            ar_held <= 1'b1;
            ar_idx <= araddr_in[7:2];
        end else if (rd_go) begin
            ar_held <= 1'b0;
        end
    end

    // Read data, unmapped words read zero with an error
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            rresp_out <= `WDG_RESP_OKAY;
        end else if (rd_go) begin
            rvalid_out <= 1'b1;
            rdata_out <= {24'h00_0000, reg_port.hit ? reg_port.rdata : 8'h00};
            rresp_out <= reg_port.hit ? `WDG_RESP_OKAY : `WDG_RESP_SLVERR;
        end else if (rready_in) begin
            rvalid_out <= 1'b0;
        end
    end
endmodule : axil_reg_slave

// ### core/windowed_countdown_watchdog.sv
// Software-refreshed countdown watchdog with AXI4-Lite registers
//
// What this block does
// R1: Countdown drops by one every 49,152 machine cycles.
// R2: Active watchdog whose countdown goes 40h to 3Fh issues a reset pulse.
// R3: Software refreshes the control register periodically with C0h to FFh.
// R4: Refresh writes the top countdown bit as one; low bits set delay.
// R5: Timeout length programmable in 64 steps of 49,152 cycles.
// R6: Disabled after reset; once active only reset can disable it.
// R7: Writing activation set with top bit clear forces a reset.
// R8: Entering stop mode while active resets; inactive, stop does nothing.
// R9: Idle mode leaves counting and timeout checking unchanged.
// R10: Bit 7 activation is set by software, cleared only by reset.
// R11: Bits 6 to 0 read back the live countdown value.
// R12: Control register reads 7Fh after reset.
// R13: Status bit 0 flags a watchdog reset; software or power-on clear it.
// R14: Reset request output spans the pulse; counters then restart.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "wdg_map.svh"
module windowed_countdown_watchdog
    import wdg_pkg::*;
#(
    parameter int unsigned STEP_CYCLES = `WDG_STEP_CYCLES,
    parameter int unsigned PULSE_CYCLES = `WDG_RESET_PULSE_CYCLES
) (
    // Clock and resets
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic por_in,
    // Processor power state
    input wire logic stop_entry_in,
    // System reset request and interrupt
    output logic reset_req_out,
    output logic irq_out,
    // AXI4-Lite write address and data
    input wire logic [7:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    // AXI4-Lite write response
    output axi_resp_t bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    // AXI4-Lite read address and data
    input wire logic [7:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output axi_resp_t rresp_out,
    output logic rvalid_out,
    input wire logic rready_in
);
    localparam int PULSE_LEN = PULSE_CYCLES;
    localparam int unsigned PW = $clog2(PULSE_CYCLES + 1);
    localparam logic [PW-1:0] PULSE_LAST = PW'(PULSE_CYCLES - 1);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    if (PULSE_CYCLES < 1) begin : g_bad_pulse
        $error("reset pulse must last at least one cycle");
    end
    if (STEP_CYCLES < 2) begin : g_bad_step
        $error("countdown step must last at least two cycles");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    wdg_reg_if reg_bus ();
    wdg_state_t state;
    wdg_state_t next_state;
    logic sys_rst;
    logic activation_bit;
    countdown_t countdown;
    logic watchdog_reset_flag;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [PW-1:0] pulse_cnt;
    logic step_tick;
    logic pulse_done;
    logic trigger;
    logic ctrl_wr;
    logic stat_wr;
    logic irq_stat_rd;
    logic mask_wr;
    logic [7:0] irq_events;

    // Either reset source clears the watchdog itself
    assign sys_rst = rst_in || por_in;

    // ------------------------------------------------------------
    // Bus slave and step prescaler
    // ------------------------------------------------------------
    axil_reg_slave #(
        .ADDR_W(8)
    ) u_slave (
        .clk_in(clk_in),
        .rst_in(sys_rst),
        .awaddr_in(awaddr_in),
        .awvalid_in(awvalid_in),
        .awready_out(awready_out),
        .wdata_in(wdata_in),
        .wstrb_in(wstrb_in),
        .wvalid_in(wvalid_in),
        .wready_out(wready_out),
        .bresp_out(bresp_out),
        .bvalid_out(bvalid_out),
        .bready_in(bready_in),
        .araddr_in(araddr_in),
        .arvalid_in(arvalid_in),
        .arready_out(arready_out),
        .rdata_out(rdata_out),
        .rresp_out(rresp_out),
        .rvalid_out(rvalid_out),
        .rready_in(rready_in),
        .reg_port(reg_bus.bus)
    );

    // Prescaler held during the pulse, restarts after it
    wdg_prescaler #(
        .CYCLES(STEP_CYCLES)
    ) u_prescaler (
        .clk_in(clk_in),
        .rst_in(sys_rst),
        .restart_in(state == ST_PULSE), // R14
        .tick_out(step_tick) // R1 R5
    );

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    assign ctrl_wr = reg_bus.wr && (reg_bus.index == `WDG_CTRL_IDX);
    assign stat_wr = reg_bus.wr && (reg_bus.index == `WDG_STAT_IDX);
    assign mask_wr = reg_bus.wr && (reg_bus.index == `WDG_IRQ_MASK_IDX);
    assign irq_stat_rd = reg_bus.rd &&
        (reg_bus.index == `WDG_IRQ_STAT_IDX);

    // Mapped words
    assign reg_bus.hit = (reg_bus.index == `WDG_CTRL_IDX) ||
        (reg_bus.index == `WDG_STAT_IDX) ||
        (reg_bus.index == `WDG_IRQ_STAT_IDX) ||
        (reg_bus.index == `WDG_IRQ_MASK_IDX);

    // Read data mux, live countdown visible
    always_comb begin
        case (reg_bus.index)
            `WDG_CTRL_IDX: reg_bus.rdata = {activation_bit, countdown}; // R11
            `WDG_STAT_IDX: reg_bus.rdata = {7'h00, watchdog_reset_flag};
            `WDG_IRQ_STAT_IDX: reg_bus.rdata = irq_status;
            `WDG_IRQ_MASK_IDX: reg_bus.rdata = irq_mask;
            default: reg_bus.rdata = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    // Timeout, forced reset and stop entry all need activation
    assign trigger = (state == ST_RUN) && activation_bit &&
        (!countdown[`WDG_CTRL_TOP_BIT] || stop_entry_in); // R2 R4 R7 R8
    assign pulse_done = (state == ST_PULSE) && (pulse_cnt == PULSE_LAST);

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (trigger) begin
                    next_state = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (pulse_done) begin
                    next_state = ST_RUN;
                end
            end
            default: next_state = ST_RUN;
        endcase
    end

    // State register
    always_ff @(posedge clk_in) begin
        if (sys_rst) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // Pulse length counter
    always_ff @(posedge clk_in) begin
        if (sys_rst || state == ST_RUN) begin
            pulse_cnt <= '0;
        end else begin
            pulse_cnt <= pulse_cnt + PW'(1); // R2
        end
    end

    // Reset request for the whole pulse
    assign reset_req_out = (state == ST_PULSE); // R14

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Activation can only be set; reset and pulse end clear it
    always_ff @(posedge clk_in) begin
        if (sys_rst || pulse_done) begin
            activation_bit <= 1'b0; // R6 R12 R14
        end else if (ctrl_wr && state == ST_RUN) begin
            activation_bit <= activation_bit |
                reg_bus.wdata[`WDG_CTRL_ACT_BIT]; // R6 R10
        end
    end

    // Countdown: write loads, tick decrements, idle mode ignored
    always_ff @(posedge clk_in) begin
        if (sys_rst || pulse_done) begin
            countdown <= `WDG_COUNT_RESET; // R12 R14
        end else if (state == ST_PULSE) begin
            countdown <= countdown;
        end else if (ctrl_wr) begin
            countdown <= reg_bus.wdata[6:0]; // R5
        end else if (step_tick) begin
            countdown <= countdown - 7'h01; // R1 R9
        end
    end

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    // Survives system reset; power-on or software write of 0 clears
    always_ff @(posedge clk_in) begin
        if (por_in) begin
            watchdog_reset_flag <= 1'b0; // R13
        end else if (trigger) begin
            watchdog_reset_flag <= 1'b1; // R13
        end else if (stat_wr && !reg_bus.wdata[`WDG_STAT_FLAG_BIT]) begin
            watchdog_reset_flag <= 1'b0; // R13
        end
    end

    // ------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------
    always_comb begin
        irq_events = 8'h00;
        irq_events[`WDG_IRQ_RESET_BIT] = trigger;
        irq_events[`WDG_IRQ_STEP_BIT] = step_tick && (state == ST_RUN);
    end

    // Sticky bits, read clears, a new event wins
    always_ff @(posedge clk_in) begin
        if (sys_rst) begin
            irq_status <= `WDG_IRQ_RESET;
        end else if (irq_stat_rd) begin
            irq_status <= irq_events;
        end else begin
            irq_status <= irq_status | irq_events;
        end
    end

    // Mask register
    always_ff @(posedge clk_in) begin
        if (sys_rst) begin
            irq_mask <= `WDG_IRQ_RESET;
        end else if (mask_wr) begin
            irq_mask <= reg_bus.wdata;
        end
    end

    // Level interrupt
    assign irq_out = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_step;
        @(posedge clk_in) disable iff (sys_rst)
        (step_tick && state == ST_RUN && !ctrl_wr && !pulse_done)
            |=> (countdown == $past(countdown) - 7'h01);
    endproperty
    a_step: assert property (p_step) // R1
        else $error("countdown did not step on tick");

    property p_timeout;
        @(posedge clk_in) disable iff (sys_rst)
        (state == ST_RUN && activation_bit && countdown == 7'h3f)
            |=> reset_req_out;
    endproperty
    a_timeout: assert property (p_timeout) // R2
        else $error("no reset after countdown reached 3Fh");

    property p_pulse_len;
        @(posedge clk_in) disable iff (sys_rst)
        $rose(reset_req_out) |-> ##PULSE_LEN !reset_req_out;
    endproperty
    a_pulse_len: assert property (p_pulse_len) // R2
        else $error("reset pulse length wrong");

    property p_pulse_hold;
        @(posedge clk_in) disable iff (sys_rst)
        $rose(reset_req_out) |-> reset_req_out[*8];
    endproperty
    a_pulse_hold: assert property (p_pulse_hold) // R14
        else $error("reset pulse ended early");

    property p_sticky;
        @(posedge clk_in) disable iff (sys_rst)
        (activation_bit && state == ST_RUN && !trigger)
            |=> activation_bit;
    endproperty
    a_sticky: assert property (p_sticky) // R6
        else $error("activation cleared without reset");

    property p_force;
        @(posedge clk_in) disable iff (sys_rst)
        (ctrl_wr && state == ST_RUN && !trigger &&
            reg_bus.wdata[7] && !reg_bus.wdata[6])
            |-> ##2 reset_req_out;
    endproperty
    a_force: assert property (p_force) // R7
        else $error("forced reset not issued");

    property p_stop;
        @(posedge clk_in) disable iff (sys_rst)
        (state == ST_RUN && stop_entry_in)
            |=> (reset_req_out == $past(activation_bit));
    endproperty
    a_stop: assert property (p_stop) // R8
        else $error("stop entry reset behaviour wrong");

    property p_restart;
        @(posedge clk_in) disable iff (sys_rst)
        $fell(reset_req_out) |->
            (countdown == 7'h7f && !activation_bit && watchdog_reset_flag);
    endproperty
    a_restart: assert property (p_restart) // R12 R13 R14
        else $error("state not restored after reset pulse");
endmodule : windowed_countdown_watchdog

// ### testbench/testbench.sv
// Self-checking bench for the countdown watchdog over its register bus
`timescale 1ns/1ps
`include "wdg_map.svh"
module testbench import wdg_pkg::*;;
    // ------------------------------------------------------------
    // Settings, signals and the block under test
    // ------------------------------------------------------------
    localparam int STEP = 16;
    localparam int PULSE = 10;
    localparam int LIMIT = 4000;
    localparam logic [7:0] CTRL_A = {`WDG_CTRL_IDX, 2'b00};
    localparam logic [7:0] STAT_A = {`WDG_STAT_IDX, 2'b00};
    localparam logic [7:0] ISTAT_A = {`WDG_IRQ_STAT_IDX, 2'b00};
    localparam logic [7:0] IMASK_A = {`WDG_IRQ_MASK_IDX, 2'b00};
    logic clk_in, rst_in, por_in, stop_entry_in, reset_req_out, irq_out;
    logic [7:0] awaddr_in, araddr_in;
    logic [31:0] wdata_in, rdata_out, rd_seen;
    logic [3:0] wstrb_in;
    logic awvalid_in, awready_out, wvalid_in, wready_out, bvalid_out;
    logic bready_in, arvalid_in, arready_out, rvalid_out, rready_in;
    axi_resp_t bresp_out, rresp_out, resp_seen;
    int miscompares, check_count, cycle_count, pulse_count, pulse_cycles;
    int w0;
    logic req_d;

    windowed_countdown_watchdog #(.STEP_CYCLES(STEP), .PULSE_CYCLES(PULSE))
    dut (.clk_in(clk_in), .rst_in(rst_in), .por_in(por_in),
        .stop_entry_in(stop_entry_in), .reset_req_out(reset_req_out),
        .irq_out(irq_out), .awaddr_in(awaddr_in), .awvalid_in(awvalid_in),
        .awready_out(awready_out), .wdata_in(wdata_in), .wstrb_in(wstrb_in),
        .wvalid_in(wvalid_in), .wready_out(wready_out),
        .bresp_out(bresp_out), .bvalid_out(bvalid_out),
        .bready_in(bready_in), .araddr_in(araddr_in),
        .arvalid_in(arvalid_in), .arready_out(arready_out),
        .rdata_out(rdata_out), .rresp_out(rresp_out),
        .rvalid_out(rvalid_out), .rready_in(rready_in));

    // Clock source
    initial begin
        clk_in = 1'b0;
        forever #25 clk_in = ~clk_in;
    end

    // Pulse bookkeeping and hang guard
    always @(posedge clk_in) begin
        if (reset_req_out === 1'b1 && req_d !== 1'b1) pulse_count++;
        if (reset_req_out === 1'b1) pulse_cycles++;
        req_d = reset_req_out;
        cycle_count++;
        if (cycle_count == LIMIT) begin
            miscompares++;
            complete_run();
        end
    end

    // ------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic bus_write(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_in);
        awaddr_in <= addr;
        wdata_in <= {24'h00_0000, data};
        awvalid_in <= 1'b1;
        wvalid_in <= 1'b1;
        bready_in <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (awvalid_in && awready_out === 1'b1) awvalid_in <= 1'b0;
            if (wvalid_in && wready_out === 1'b1) wvalid_in <= 1'b0;
            if (bvalid_out === 1'b1) begin
                resp_seen = bresp_out;
                bready_in <= 1'b0;
                break;
            end
        end
    endtask : bus_write

    task automatic bus_read(input logic [7:0] addr);
        @(posedge clk_in);
        araddr_in <= addr;
        arvalid_in <= 1'b1;
        rready_in <= 1'b1;
        forever begin
            @(posedge clk_in);
            if (arvalid_in && arready_out === 1'b1) arvalid_in <= 1'b0;
            if (rvalid_out === 1'b1) begin
                rd_seen = rdata_out;
                resp_seen = rresp_out;
                rready_in <= 1'b0;
                break;
            end
        end
    endtask : bus_read

    task automatic rd_check(input string name, input logic [7:0] addr,
                            input logic [31:0] exp);
        bus_read(addr);
        check(name, rd_seen, exp);
    endtask : rd_check

    task automatic wait_pulse_end();
        do @(posedge clk_in); while (reset_req_out !== 1'b1);
        do @(posedge clk_in); while (reset_req_out === 1'b1);
    endtask : wait_pulse_end

    task automatic pulse_stop();
        @(posedge clk_in);
        stop_entry_in <= 1'b1;
        @(posedge clk_in);
        stop_entry_in <= 1'b0;
    endtask : pulse_stop

    task automatic hold_reset(input logic sys, input logic pwr);
        @(posedge clk_in);
        rst_in <= sys;
        por_in <= pwr;
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
        por_in <= 1'b0;
    endtask : hold_reset

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_in, por_in} = 2'b11;
        {stop_entry_in, awvalid_in, wvalid_in, bready_in} = 4'h0;
        {arvalid_in, rready_in} = 2'b00;
        {awaddr_in, araddr_in} = 16'h0000;
        wdata_in = 32'h0000_0000;
        wstrb_in = 4'hf;
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        por_in <= 1'b0;
        // Reset values and an unmapped place
        rd_check("ctrl reset", CTRL_A, 32'h0000_007f);
        rd_check("flag reset", STAT_A, 32'h0000_0000);
        rd_check("unmapped data", 8'h00, 32'h0000_0000);
        check("unmapped rresp", 32'(resp_seen), 32'(`WDG_RESP_SLVERR));
        bus_write(8'h04, 8'h55);
        check("unmapped bresp", 32'(resp_seen), 32'(`WDG_RESP_SLVERR));
        $display("test reset values done");
        // Inactive watchdog ignores top bit clear and stop entry
        bus_write(CTRL_A, 8'h3f);
        pulse_stop();
        repeat (20) @(posedge clk_in);
        check("inactive pulses", 32'(pulse_count), 0);
        bus_read(CTRL_A);
        check("activation off", 32'(rd_seen[7]), 0);
        $display("test inactive done");
        // Forced reset, pulse length, restart and step rate
        w0 = pulse_cycles;
        bus_write(CTRL_A, 8'hbf);
        wait_pulse_end();
        check("forced pulses", 32'(pulse_count), 1);
        check("pulse length", 32'(pulse_cycles - w0), 32'(PULSE));
        rd_check("ctrl restart", CTRL_A, 32'h0000_007f);
        rd_check("flag set", STAT_A, 32'h0000_0001);
        repeat (8) @(posedge clk_in);
        rd_check("one step", CTRL_A, 32'h0000_007e);
        $display("test forced reset done");
        // Timeout from 41h: no pulse before the 40h to 3Fh step
        w0 = pulse_cycles;
        bus_write(CTRL_A, 8'hc1);
        repeat (12) @(posedge clk_in);
        check("early pulse", 32'(pulse_count), 1);
        wait_pulse_end();
        check("timeout pulses", 32'(pulse_count), 2);
        check("timeout length", 32'(pulse_cycles - w0), 32'(PULSE));
        check("irq masked", 32'(irq_out), 0);
        bus_write(IMASK_A, 8'h01);
        check("irq raised", 32'(irq_out), 1);
        bus_read(ISTAT_A);
        check("irq event", 32'(rd_seen[0]), 1);
        repeat (2) @(posedge clk_in);
        check("irq cleared", 32'(irq_out), 0);
        $display("test timeout done");
        // Activation cannot be cleared by software; resets and the flag
        bus_write(CTRL_A, 8'hff);
        bus_write(CTRL_A, 8'h7f);
        bus_read(CTRL_A);
        check("activation kept", 32'(rd_seen[7]), 1);
        hold_reset(1'b1, 1'b0);
        rd_check("ctrl after reset", CTRL_A, 32'h0000_007f);
        rd_check("flag kept", STAT_A, 32'h0000_0001);
        wstrb_in <= 4'he;
        bus_write(STAT_A, 8'h00);
        wstrb_in <= 4'hf;
        rd_check("flag no lane", STAT_A, 32'h0000_0001);
        hold_reset(1'b0, 1'b1);
        rd_check("flag power clear", STAT_A, 32'h0000_0000);
        $display("test activation done");
        // Stop entry while active
        bus_write(CTRL_A, 8'hff);
        pulse_stop();
        wait_pulse_end();
        check("stop pulses", 32'(pulse_count), 3);
        rd_check("flag stop", STAT_A, 32'h0000_0001);
        bus_write(STAT_A, 8'h00);
        rd_check("flag sw clear", STAT_A, 32'h0000_0000);
        $display("test stop entry done");
        complete_run();
    end
endmodule : testbench
